// ===== shared/ssec_pkg.sv
/*
 Constants, encodings and types for the supervisor with serial EEPROM.
 Assumes a 50 MHz core clock and an SPI master on a separate serial clock.
*/
package ssec_pkg;
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
   localparam int unsigned RST_DELAY_MS = 200;
   localparam int unsigned DOG_LONG_MS = 1400;
   localparam int unsigned DOG_MID_MS = 600;
   localparam int unsigned DOG_SHORT_MS = 200;
   localparam int unsigned RST_DELAY_CYC = RST_DELAY_MS * CYC_PER_MS;
   localparam int unsigned DOG_LONG_CYC = DOG_LONG_MS * CYC_PER_MS;
   localparam int unsigned DOG_MID_CYC = DOG_MID_MS * CYC_PER_MS;
   localparam int unsigned DOG_SHORT_CYC = DOG_SHORT_MS * CYC_PER_MS;
   localparam int unsigned NV_WRITE_CYC = 4000;
   localparam int unsigned ADDR_W = 13;
   localparam int unsigned MEM_BYTES = 8192;
   localparam int unsigned PAGE_W = 5;
   localparam int unsigned PAGE_BYTES = 32;
   localparam logic [7:0] OP_SET_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] OP_SET_FLAG = 8'h00;
   localparam logic [7:0] OP_CLEAR_LATCHES = 8'h04;
   localparam logic [7:0] OP_READ_STATUS = 8'h05;
   localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
   localparam logic [7:0] OP_READ_ARRAY = 8'h03;
   localparam logic [7:0] OP_WRITE_ARRAY = 8'h02;
   localparam int unsigned SR_PROTECT_ENABLE = 7;
   localparam int unsigned SR_FLAG_LATCH = 6;
   localparam int unsigned SR_DOG_HI = 5;
   localparam int unsigned SR_DOG_LO = 4;
   localparam int unsigned SR_LOCK_HI = 3;
   localparam int unsigned SR_LOCK_LO = 2;
   localparam int unsigned SR_WRITE_ENABLE = 1;
   localparam int unsigned SR_WRITE_BUSY = 0;
   localparam logic [1:0] DOG_PERIOD_RST = 2'h0;
   localparam logic [1:0] LOCK_LEVEL_RST = 2'h0;
   localparam logic PROTECT_ENABLE_RST = 1'b0;
   localparam logic [1:0] DOG_LONG = 2'h0;
   localparam logic [1:0] DOG_MID = 2'h1;
   localparam logic [1:0] DOG_SHORT = 2'h2;
   localparam logic [1:0] DOG_OFF = 2'h3;
   localparam logic [1:0] LOCK_NONE = 2'h0;
   localparam logic [1:0] LOCK_QUARTER = 2'h1;
   localparam logic [1:0] LOCK_HALF = 2'h2;
   localparam logic [12:0] LOCK_QUARTER_BASE = 13'h1800;
   localparam logic [12:0] LOCK_HALF_BASE = 13'h1000;
   localparam logic [2:0] BYTES_SAT = 3'h4;
   typedef enum logic [1:0] {
      NV_IDLE = 2'b00,
      NV_ARRAY = 2'b01,
      NV_STATUS = 2'b11
   } ssec_nv_state_type;
endpackage

// ===== rtl/ssec_top.sv
/*
 Supervisor core: reset timer, watchdog, SPI command interpreter, status
 register, write protection and the byte array with its self-timed write.
 Assumes an SPI master in mode 0 or 3 that stops SCK while select is high,
 and a supply comparator level on supply_above_trip.
*/
`timescale 1ns/1ps
module ssec_top
   import ssec_pkg::*;
#(
   parameter int unsigned RST_CYC = RST_DELAY_CYC,
   parameter int unsigned DOG_LONG_N = DOG_LONG_CYC,
   parameter int unsigned DOG_MID_N = DOG_MID_CYC,
   parameter int unsigned DOG_SHORT_N = DOG_SHORT_CYC,
   parameter int unsigned NV_CYC = NV_WRITE_CYC
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic sck,
   input wire logic select_kick_pin_n,
   input wire logic si,
   input wire logic write_protect_n,
   input wire logic supply_above_trip,
   output logic so_o,
   output logic so_oe,
   output logic reset_pin_o,
   output logic reset_pin_oe
);
   // serial side, sck domain
   logic in_frame_q;
   logic frame_tgl_q;
   logic [7:0] shift_q;
   logic [2:0] bitcnt_q;
   logic [2:0] bytecnt_q;
   logic [7:0] op_q;
   logic [7:0] addr_hi_q;
   logic [7:0] sr_data_q;
   logic [ADDR_W-1:0] rd_addr_q;
   logic [ADDR_W-PAGE_W-1:0] page_q;
   logic [PAGE_W-1:0] ptr_q;
   logic [7:0] page_buf [PAGE_BYTES];
   logic [PAGE_BYTES-1:0] mask_q;
   logic [7:0] tx_q;
   logic reading_q;
   logic so_q;
   logic so_oe_q;
   logic [7:0] sr_meta_q;
   logic [7:0] sr_sync_q;
   logic [2:0] bc;
   logic [2:0] byt;
   logic [7:0] nb;
   logic [ADDR_W-1:0] full_addr;
   // core side
   logic [7:0] mem [MEM_BYTES];
   logic cs_meta_q, cs_sync_q, cs_prev_q;
   logic wp_meta_q, wp_sync_q;
   logic sup_meta_q, sup_sync_q;
   logic tgl_meta_q, tgl_sync_q, tgl_seen_q;
   logic cs_rise, cs_fall, commit;
   logic one_byte, two_bytes, has_data;
   logic wel_q, flag_q, pe_q;
   logic [1:0] wd_q, bl_q;
   logic [7:0] staged_sr_q;
   ssec_nv_state_type nv_state_q;
   logic [31:0] nv_cnt_q;
   logic nv_busy, nv_done;
   logic [PAGE_W-1:0] idx;
   logic [ADDR_W-1:0] wr_addr;
   logic [31:0] dog_cnt_q, dog_limit;
   logic dog_fire;
   logic [31:0] rst_cnt_q;
   logic reset_act_q;

   function automatic logic locked(input logic [ADDR_W-1:0] a, input logic [1:0] lvl);
      unique case (lvl)
         LOCK_NONE: locked = 1'b0;
         LOCK_QUARTER: locked = (a >= LOCK_QUARTER_BASE);
         LOCK_HALF: locked = (a >= LOCK_HALF_BASE);
         default: locked = 1'b1;
      endcase
   endfunction

   // a frame starts at its first rising edge; counts stay put after select rises
   always_comb begin
      bc = in_frame_q ? bitcnt_q : 3'h0;
      byt = in_frame_q ? bytecnt_q : 3'h0;
      nb = {shift_q[6:0], si};
      full_addr = {addr_hi_q[ADDR_W-9:0], nb};
   end

   always_ff @(posedge sck or posedge select_kick_pin_n) begin
      if (select_kick_pin_n) begin
         in_frame_q <= 1'b0;
      end else begin
         in_frame_q <= 1'b1;
      end
   end

   // frame marker needs a known start or no frame would ever commit;
   // sck is still during reset, so clearing it here cannot race an edge
   always_ff @(posedge sck or negedge rst_n) begin
      if (!rst_n) begin
         frame_tgl_q <= 1'b0;
      end else if (!in_frame_q) begin
         frame_tgl_q <= ~frame_tgl_q;
      end
   end

   // no cs reset here: the core reads these after the frame ends
   always_ff @(posedge sck) begin
      shift_q <= nb;
      bitcnt_q <= bc + 3'h1;
      if (bc == 3'h7) begin
         bytecnt_q <= (byt == BYTES_SAT) ? BYTES_SAT : byt + 3'h1;
      end else begin
         bytecnt_q <= byt;
      end
      sr_meta_q <= {pe_q, flag_q, wd_q, bl_q, wel_q, nv_busy};
      sr_sync_q <= sr_meta_q;
   end

   always_ff @(posedge sck) begin
      if (!in_frame_q) begin
         reading_q <= 1'b0;
      end
      if (bc == 3'h7) begin
         if (byt == 3'h0) begin
            op_q <= nb;
            if (nb == OP_READ_STATUS) begin
               tx_q <= sr_sync_q;
               reading_q <= 1'b1;
            end
            if (nb == OP_WRITE_ARRAY && !sr_sync_q[SR_WRITE_BUSY]) begin
               mask_q <= '0;
            end
         end else if (op_q == OP_READ_STATUS) begin
            tx_q <= sr_sync_q;
         end else if (byt == 3'h1) begin
            addr_hi_q <= nb;
            sr_data_q <= nb;
         end else if (byt == 3'h2) begin
            page_q <= full_addr[ADDR_W-1:PAGE_W];
            ptr_q <= full_addr[PAGE_W-1:0];
            if (op_q == OP_READ_ARRAY) begin
               tx_q <= mem[full_addr];
               rd_addr_q <= full_addr + 13'h0001;
               reading_q <= 1'b1;
            end
         end else if (op_q == OP_READ_ARRAY) begin
            tx_q <= mem[rd_addr_q];
            rd_addr_q <= rd_addr_q + 13'h0001;
         end else if (op_q == OP_WRITE_ARRAY && !sr_sync_q[SR_WRITE_BUSY]) begin
            page_buf[ptr_q] <= nb;
            mask_q[ptr_q] <= 1'b1;
            ptr_q <= ptr_q + 5'h01;
         end
      end
   end

   // output bit moves on the falling edge, released as soon as select rises
   always_ff @(negedge sck or posedge select_kick_pin_n) begin
      if (select_kick_pin_n) begin
         so_q <= 1'b0;
         so_oe_q <= 1'b0;
      end else begin
         so_q <= tx_q[~bitcnt_q];
         so_oe_q <= reading_q && in_frame_q;
      end
   end

   assign so_o = so_q;
   assign so_oe = so_oe_q;

   // core clock synchronisers
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         cs_meta_q <= 1'b1;
         cs_sync_q <= 1'b1;
         cs_prev_q <= 1'b1;
         wp_meta_q <= 1'b1;
         wp_sync_q <= 1'b1;
         sup_meta_q <= 1'b0;
         sup_sync_q <= 1'b0;
         tgl_meta_q <= 1'b0;
         tgl_sync_q <= 1'b0;
         tgl_seen_q <= 1'b0;
      end else begin
         cs_meta_q <= select_kick_pin_n;
         cs_sync_q <= cs_meta_q;
         cs_prev_q <= cs_sync_q;
         wp_meta_q <= write_protect_n;
         wp_sync_q <= wp_meta_q;
         sup_meta_q <= supply_above_trip;
         sup_sync_q <= sup_meta_q;
         tgl_meta_q <= frame_tgl_q;
         tgl_sync_q <= tgl_meta_q;
         if (cs_rise) begin
            tgl_seen_q <= tgl_sync_q;
         end
      end
   end

   // frame results are quiet once select is high and SCK has stopped
   always_comb begin
      cs_rise = cs_sync_q && !cs_prev_q;
      cs_fall = !cs_sync_q && cs_prev_q;
      commit = cs_rise && (tgl_sync_q != tgl_seen_q) && !nv_busy;
      one_byte = (bitcnt_q == 3'h0) && (bytecnt_q == 3'h1);
      two_bytes = (bitcnt_q == 3'h0) && (bytecnt_q == 3'h2);
      has_data = (bitcnt_q == 3'h0) && (bytecnt_q == BYTES_SAT);
      nv_busy = (nv_state_q != NV_IDLE);
      nv_done = nv_busy && (nv_cnt_q == NV_CYC - 1);
      idx = nv_cnt_q[PAGE_W-1:0];
      wr_addr = {page_q, idx};
   end

   // self-timed write: fixed up-count of NV_CYC cycles, busy bit high throughout
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         nv_state_q <= NV_IDLE;
         nv_cnt_q <= '0;
      end else begin
         unique case (nv_state_q)
            NV_IDLE: begin
               nv_cnt_q <= '0;
               if (commit && wel_q && op_q == OP_WRITE_ARRAY && has_data) begin
                  nv_state_q <= NV_ARRAY;
               end else if (commit && wel_q && op_q == OP_WRITE_STATUS && two_bytes
                            && !(!wp_sync_q && pe_q)) begin
                  nv_state_q <= NV_STATUS;
               end
            end
            NV_ARRAY, NV_STATUS: begin
               nv_cnt_q <= nv_cnt_q + 32'h1;
               if (nv_done) begin
                  nv_state_q <= NV_IDLE;
               end
            end
            default: nv_state_q <= NV_IDLE;
         endcase
      end
   end

   // page copy in the first PAGE_BYTES cycles of the count
   always_ff @(posedge core_clk) begin
      if (nv_state_q == NV_ARRAY && nv_cnt_q < PAGE_BYTES && mask_q[idx]
          && !locked(wr_addr, bl_q)) begin
         mem[wr_addr] <= page_buf[idx];
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         wel_q <= 1'b0;
         flag_q <= 1'b0;
         pe_q <= PROTECT_ENABLE_RST;
         wd_q <= DOG_PERIOD_RST;
         bl_q <= LOCK_LEVEL_RST;
         staged_sr_q <= '0;
      end else if (nv_done) begin
         wel_q <= 1'b0;
         if (nv_state_q == NV_STATUS) begin
            pe_q <= staged_sr_q[SR_PROTECT_ENABLE];
            flag_q <= staged_sr_q[SR_FLAG_LATCH];
            wd_q <= staged_sr_q[SR_DOG_HI:SR_DOG_LO];
            bl_q <= staged_sr_q[SR_LOCK_HI:SR_LOCK_LO];
         end
      end else if (commit && one_byte) begin
         if (op_q == OP_SET_WRITE_ENABLE) begin
            wel_q <= 1'b1;
         end else if (op_q == OP_SET_FLAG) begin
            flag_q <= 1'b1;
         end else if (op_q == OP_CLEAR_LATCHES) begin
            wel_q <= 1'b0;
            flag_q <= 1'b0;
         end
      end else if (commit) begin
         staged_sr_q <= sr_data_q;
      end
   end

   // watchdog on the core timebase, cleared by each select falling edge
   always_comb begin
      unique case (wd_q)
         DOG_LONG: dog_limit = DOG_LONG_N;
         DOG_MID: dog_limit = DOG_MID_N;
         DOG_SHORT: dog_limit = DOG_SHORT_N;
         default: dog_limit = 32'h1;
      endcase
      dog_fire = (wd_q != DOG_OFF) && !reset_act_q && (dog_cnt_q == dog_limit - 32'h1);
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         dog_cnt_q <= '0;
      end else if (reset_act_q || cs_fall || wd_q == DOG_OFF || dog_fire) begin
         dog_cnt_q <= '0;
      end else begin
         dog_cnt_q <= dog_cnt_q + 32'h1;
      end
   end

   // reset output: held while supply low or after a bite, then the delay
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rst_cnt_q <= '0;
         reset_act_q <= 1'b1;
      end else begin
         if (!sup_sync_q || dog_fire) begin
            rst_cnt_q <= '0;
         end else if (rst_cnt_q != RST_CYC) begin
            rst_cnt_q <= rst_cnt_q + 32'h1;
         end
         reset_act_q <= !(sup_sync_q && !dog_fire && rst_cnt_q == RST_CYC);
      end
   end

   // open drain: the pin is pulled low whenever reset is active
   assign reset_pin_o = 1'b0;
   assign reset_pin_oe = reset_act_q;

   sequence s_busy_run;
      nv_busy [*8];
   endsequence

   a_reset_supply_low: assert property (
      @(posedge core_clk) disable iff (!rst_n) !sup_sync_q |=> reset_act_q)
      else $error("reset not active with supply low");
   a_reset_release_delay: assert property (
      @(posedge core_clk) disable iff (!rst_n) $fell(reset_act_q) |-> rst_cnt_q == RST_CYC)
      else $error("reset released before delay");
   a_dog_bite_reset: assert property (
      @(posedge core_clk) disable iff (!rst_n) dog_fire |=> reset_act_q ##1 rst_cnt_q <= 1)
      else $error("watchdog expiry did not reset");
   a_dog_kick_clear: assert property (
      @(posedge core_clk) disable iff (!rst_n) cs_fall |=> dog_cnt_q == 0)
      else $error("select fall did not restart watchdog");
   a_dog_off_quiet: assert property (
      @(posedge core_clk) disable iff (!rst_n) wd_q == DOG_OFF |=> dog_cnt_q == 0 && !dog_fire)
      else $error("disabled watchdog fired");
   a_busy_hold_run: assert property (
      @(posedge core_clk) disable iff (!rst_n) $rose(nv_busy) |-> s_busy_run)
      else $error("write cycle ended too early");
   a_enable_clear_done: assert property (
      @(posedge core_clk) disable iff (!rst_n) $fell(nv_busy) |-> !wel_q)
      else $error("enable latch survived write cycle");
   a_status_write_locked: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      commit && op_q == OP_WRITE_STATUS && !wp_sync_q && pe_q |=> !nv_busy)
      else $error("status write accepted while locked");
   a_no_enable_write: assert property (
      @(posedge core_clk) disable iff (!rst_n) commit && !wel_q |=> !nv_busy)
      else $error("write started without enable latch");
endmodule // ssec_top

// ===== dv/ssec_host.sv
/*
 SPI master model standing in for the host microcontroller.
 Assumes mode 0 with a 6 ns link period; sck runs only inside frames.
*/
`timescale 1ns/1ps
module ssec_host (
   output logic sck,
   output logic select_kick_pin_n,
   output logic si,
   input wire logic so_o,
   input wire logic so_oe
);
   logic [7:0] rxq [$];

   initial begin
      sck = 1'b0;
      select_kick_pin_n = 1'b1;
      si = 1'b0;
   end

   // one select low for the whole byte list, select rise closes it
   task automatic frame(input logic [7:0] txq [$], input bit slow);
      logic [7:0] b;
      rxq = {};
      select_kick_pin_n = 1'b0;
      #3;
      foreach (txq[k]) begin
         for (int i = 7; i >= 0; i--) begin
            si = txq[k][i];
            #3 sck = 1'b1;
            // undriven so reads as unknown so it can never match
            b = {b[6:0], so_oe ? so_o : 1'bx};
            #3 sck = 1'b0;
            // stopped clock mid-address; state must survive
            if (slow && k == 1 && i == 4) #40;
         end
         rxq.push_back(b);
      end
      // inverted data line shows no stale level
      si = ~si;
      #3 select_kick_pin_n = 1'b1;
      #160;
   endtask

   // bare high-to-low on select restarts the dog
   task automatic kick();
      select_kick_pin_n = 1'b0;
      #20 select_kick_pin_n = 1'b1;
   endtask
endmodule // ssec_host

// ===== dv/supervisor_spi_eeprom_ctrl_bench.sv
/*
 Self-checking bench for the supervisor core: reset, supply and protect pins,
 SPI traffic through the host model, results compared with an integer model.
 Assumes ssec_pkg, ssec_top and ssec_host are compiled first.
*/
`timescale 1ns/1ps
module supervisor_spi_eeprom_ctrl_bench
   import ssec_pkg::*;
;
   localparam int RST_N = 50;
   localparam int NV_N = 64;
   localparam int DOG_L = 400;
   localparam int DOG_M = 300;
   localparam int DOG_S = 200;
   logic core_clk, rst_n, write_protect_n, supply_above_trip;
   logic sck, select_kick_pin_n, si, so_o, so_oe, reset_pin_o, reset_pin_oe;
   int fail_count = 0;
   int n_compared = 0;
   int mem [int];
   logic pe, flag, write_enable_latch, busy;
   logic [1:0] wd, bl;
   logic [7:0] q [$];
   logic [7:0] ops [3] = '{OP_SET_FLAG, OP_SET_WRITE_ENABLE, OP_CLEAR_LATCHES};

   ssec_top #(.RST_CYC(RST_N), .DOG_LONG_N(DOG_L), .DOG_MID_N(DOG_M),
      .DOG_SHORT_N(DOG_S), .NV_CYC(NV_N)) DUT (
      .core_clk(core_clk), .rst_n(rst_n), .sck(sck), .select_kick_pin_n(select_kick_pin_n),
      .si(si), .write_protect_n(write_protect_n), .supply_above_trip(supply_above_trip),
      .so_o(so_o), .so_oe(so_oe), .reset_pin_o(reset_pin_o), .reset_pin_oe(reset_pin_oe));
   ssec_host host (.sck(sck), .select_kick_pin_n(select_kick_pin_n), .si(si),
      .so_o(so_o), .so_oe(so_oe));

   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic stop_test();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   function automatic int dog_n(int p);
      return p == 0 ? DOG_L : (p == 1 ? DOG_M : DOG_S);
   endfunction

   function automatic bit locked(int a);
      return bl == 2'h3 || (bl == 2'h2 && a >= 32'h1000) || (bl == 2'h1 && a >= 32'h1800);
   endfunction

   task automatic rdsr();
      q = {OP_READ_STATUS, 8'h00};
      host.frame(q, 1'b0);
      check(host.rxq[1], {pe, flag, wd, bl, write_enable_latch, busy}, "status");
   endtask

   task automatic cmd(input logic [7:0] op);
      q = {op};
      host.frame(q, 1'b0);
      case (op)
         OP_SET_WRITE_ENABLE: write_enable_latch = 1'b1;
         OP_SET_FLAG: flag = 1'b1;
         OP_CLEAR_LATCHES: {write_enable_latch, flag} = 2'b00;
         default: ;
      endcase
   endtask

   task automatic op_write_status(input logic [7:0] v);
      q = {OP_WRITE_STATUS, v & 8'hFC};
      host.frame(q, 1'b0);
      if (write_enable_latch && !(!write_protect_n && pe)) begin
         busy = 1'b1;
         rdsr();
         repeat (NV_N + 10) @(posedge core_clk);
         {pe, flag, wd, bl} = v[7:2];
         {write_enable_latch, busy} = 2'b00;
      end
      rdsr();
   endtask

   task automatic wr(input int addr, input int n);
      int a;
      q = {OP_WRITE_ARRAY, 8'(addr >> 8), 8'(addr)};
      for (int j = 0; j < n; j++) q.push_back(8'($urandom));
      host.frame(q, 1'b0);
      if (write_enable_latch) begin
         for (int j = 0; j < n; j++) begin
            a = (addr & 32'h1FE0) | ((addr + j) & 32'h1F);
            if (!locked(a)) mem[a] = q[3 + j];
         end
         repeat (NV_N + 10) @(posedge core_clk);
         write_enable_latch = 1'b0;
      end
   endtask

   task automatic rd(input int addr, input int n, input bit slow);
      int a;
      q = {OP_READ_ARRAY, 8'(addr >> 8), 8'(addr)};
      for (int j = 0; j < n; j++) q.push_back(8'h00);
      host.frame(q, slow);
      for (int j = 0; j < n; j++) begin
         a = (addr + j) & 32'h1FFF;
         if (mem.exists(a)) check(host.rxq[3 + j], 16'(mem[a]), "array read");
      end
   endtask

   task automatic await_pin(input logic lvl, input int lo, input int hi);
      int cnt;
      cnt = 0;
      while (reset_pin_oe !== lvl && cnt <= hi) begin
         @(posedge core_clk);
         #1 cnt++;
      end
      check(16'(cnt >= lo && cnt <= hi), 16'h0001, "reset pin timing");
   endtask

   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   // whole run is near 5k cycles; far beyond that means a hang
   initial begin
      #400000;
      fail_count++;
      stop_test();
   end

   initial begin
      void'($urandom(32'h8C07));
      rst_n = 1'b0;
      write_protect_n = 1'b1;
      supply_above_trip = 1'b0;
      {pe, flag, wd, bl, write_enable_latch, busy} = 8'h00;
      repeat (5) @(posedge core_clk);
      #1 check(reset_pin_oe, 1'b1, "reset held");
      @(posedge core_clk);
      rst_n <= 1'b1;
      supply_above_trip <= 1'b1;
      await_pin(1'b0, RST_N, RST_N + 6);
      @(posedge core_clk);
      supply_above_trip <= 1'b0;
      await_pin(1'b1, 1, 5);
      @(posedge core_clk);
      supply_above_trip <= 1'b1;
      await_pin(1'b0, RST_N, RST_N + 6);
      rdsr();
      foreach (ops[i]) begin
         cmd(ops[i]);
         rdsr();
      end
      op_write_status(8'h30);
      q = {OP_SET_WRITE_ENABLE, OP_WRITE_STATUS, 8'h30};
      host.frame(q, 1'b0);
      rdsr();
      cmd(OP_SET_WRITE_ENABLE);
      op_write_status(8'h74);
      cmd(OP_CLEAR_LATCHES);
      cmd(OP_SET_WRITE_ENABLE);
      op_write_status(8'h30);
      cmd(OP_SET_WRITE_ENABLE);
      wr(32'h1FFE, 34);
      cmd(OP_SET_WRITE_ENABLE);
      wr(32'h0000, 2);
      rdsr();
      rd(32'h1FE0, 32, 1'b0);
      rd(32'h1FFE, 4, 1'b1);
      for (int b = 1; b < 4; b++) begin
         cmd(OP_SET_WRITE_ENABLE);
         op_write_status(8'(32'h30 | (b << 2)));
         cmd(OP_SET_WRITE_ENABLE);
         wr(32'h1FE5, 1);
         cmd(OP_SET_WRITE_ENABLE);
         wr(32'h0000, 1);
         cmd(OP_CLEAR_LATCHES);
         rd(32'h1FFE, 4, 1'b0);
         rd(32'h1FE5, 1, 1'b0);
      end
      cmd(OP_SET_WRITE_ENABLE);
      op_write_status(8'hB0);
      @(posedge core_clk);
      write_protect_n <= 1'b0;
      cmd(OP_SET_WRITE_ENABLE);
      op_write_status(8'h30);
      cmd(OP_CLEAR_LATCHES);
      rdsr();
      @(posedge core_clk);
      write_protect_n <= 1'b1;
      cmd(OP_SET_WRITE_ENABLE);
      op_write_status(8'h30);
      for (int p = 0; p < 3; p++) begin
         cmd(OP_SET_WRITE_ENABLE);
         op_write_status(8'(p << 4));
         host.kick();
         repeat (dog_n(p) * 3 / 4) @(posedge core_clk);
         host.kick();
         await_pin(1'b1, dog_n(p), dog_n(p) + 6);
         await_pin(1'b0, RST_N, RST_N + 3);
      end
      cmd(OP_SET_WRITE_ENABLE);
      op_write_status(8'h30);
      host.kick();
      repeat (500) @(posedge core_clk);
      #1 check(reset_pin_oe, 1'b0, "dog disabled");
      check(reset_pin_o, 1'b0, "open drain level");
      stop_test();
   end
endmodule // supervisor_spi_eeprom_ctrl_bench
